//--- asm_pkg.sv
`default_nettype none
package asm_pkg;
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_PS = 25000;
    localparam int ADDR_TO_DATA_DELAY_PS = 20000;
    localparam int SELECT_TO_DATA_DELAY_PS = 20000;
    localparam int OUTEN_TO_DATA_DELAY_PS = 10000;
    localparam int MIN_READ_PERIOD_PS = 20000;
    localparam int WRITE_WIDTH_PS = 20000;
    localparam int WRITE_TO_FLOAT_DELAY_PS = 10000;
    localparam int READ_WAIT_CYC = (ADDR_TO_DATA_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int WRITE_WIDTH_CYC = (WRITE_WIDTH_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS + 1;
    localparam int FLOAT_WAIT_CYC = (WRITE_TO_FLOAT_DELAY_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    typedef logic [3:0] asm_cnt_t;
endpackage : asm_pkg
`default_nettype wire

//--- asm_timer.sv
`timescale 1ns/1ps
`default_nettype none
module asm_timer (
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire asm_pkg::asm_cnt_t value,
    output logic done
);
    import asm_pkg::*;
    typedef struct packed {
        asm_cnt_t cnt;
    } asm_tmr_s;
    asm_tmr_s st_r;
    asm_tmr_s st_nxt;
    always_comb begin
        st_nxt = st_r;
        if (load) begin
            st_nxt.cnt = value;
        end else if (st_r.cnt != CNT_ZERO) begin
            st_nxt.cnt = st_r.cnt - 4'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign done = (st_r.cnt == CNT_ZERO) && !load;
endmodule : asm_timer
`default_nettype wire

//--- asm_host.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Host holds address one read period.
// - Select read with steady address, outen.
// - Strobe-ended write keeps full pulse width.
// - Host drives data with the strobe; outen already high.
module asm_host (
    input wire logic CLK,
    input wire logic RST,
    input wire logic REQ_VALID,
    input wire logic REQ_WRITE,
    input wire logic [asm_pkg::ADDR_W-1:0] REQ_ADDR,
    input wire logic [asm_pkg::DATA_W-1:0] REQ_WDATA,
    output logic REQ_READY,
    output logic RSP_VALID,
    output logic [asm_pkg::DATA_W-1:0] RSP_RDATA,
    output logic [asm_pkg::ADDR_W-1:0] MEM_ADDR,
    output logic MEM_SEL_N,
    output logic MEM_WSTROBE_N,
    output logic MEM_OUTEN_N,
    input wire logic [asm_pkg::DATA_W-1:0] MEM_DQ_I,
    output logic [asm_pkg::DATA_W-1:0] MEM_DQ_O,
    output logic MEM_DQ_OE
);
    import asm_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_READ  = 4'b0010,
        S_WRITE = 4'b0100,
        S_DONE  = 4'b1000
    } asm_state_e;

    typedef struct packed {
        asm_state_e st;
        logic ready;
        logic rsp;
        logic [DATA_W-1:0] rdata;
        logic [ADDR_W-1:0] addr;
        logic sel_n;
        logic we_n;
        logic oe_n;
        logic [DATA_W-1:0] dq_o;
        logic dq_oe;
        logic [DATA_W-1:0] dq_s1;
        logic [DATA_W-1:0] dq_s2;
    } asm_host_s;

    asm_host_s s_r;
    asm_host_s s_nxt;
    logic tmr_load;
    asm_cnt_t tmr_val;
    logic tmr_done;

    asm_timer u_timer (
        .clk(CLK),
        .rst(RST),
        .load(tmr_load),
        .value(tmr_val),
        .done(tmr_done)
    );

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    always_comb begin
        s_nxt = s_r;
        tmr_load = 1'b0;
        tmr_val = CNT_ZERO;
        s_nxt.dq_s1 = MEM_DQ_I;
        s_nxt.dq_s2 = s_r.dq_s1;
        s_nxt.rsp = 1'b0;
        case (s_r.st)
            S_IDLE: begin
                if (REQ_VALID && s_r.ready) begin
                    s_nxt.ready = 1'b0;
                    s_nxt.addr = REQ_ADDR;
                    s_nxt.sel_n = 1'b0;
                    tmr_load = 1'b1;
                    if (REQ_WRITE) begin
                        // float before drive
                        // Output enable stays high, so the memory is already floating.
                        s_nxt.oe_n = 1'b1;
                        s_nxt.we_n = 1'b0;
                        s_nxt.dq_o = REQ_WDATA;
                        s_nxt.dq_oe = 1'b1;
                        tmr_val = asm_cnt_t'(WRITE_WIDTH_CYC);
                        s_nxt.st = S_WRITE;
                    end else begin
                        s_nxt.oe_n = 1'b0;
                        s_nxt.we_n = 1'b1;
                        tmr_val = asm_cnt_t'(READ_WAIT_CYC + 2);
                        s_nxt.st = S_READ;
                    end
                end
            end
            S_READ: begin
                // hold address
                // The extra two cycles cover the input synchroniser.
                if (tmr_done) begin
                    s_nxt.rdata = s_r.dq_s2;
                    s_nxt.rsp = 1'b1;
                    s_nxt.sel_n = 1'b1;
                    s_nxt.oe_n = 1'b1;
                    s_nxt.st = S_DONE;
                end
            end
            S_WRITE: begin
                if (tmr_done) begin
                    s_nxt.we_n = 1'b1;
                    s_nxt.st = S_DONE;
                end
            end
            S_DONE: begin
                // select released after strobe
                // Data and select drop one cycle after the strobe rises for hold margin.
                s_nxt.sel_n = 1'b1;
                s_nxt.dq_oe = 1'b0;
                s_nxt.ready = 1'b1;
                s_nxt.st = S_IDLE;
            end
            default: begin
                s_nxt.st = S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            s_r <= '0;
            s_r.st <= S_IDLE;
            s_r.ready <= 1'b1;
            s_r.sel_n <= 1'b1;
            s_r.we_n <= 1'b1;
            s_r.oe_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Every pin comes straight from the state register, so no glitch reaches the memory.
    assign REQ_READY = s_r.ready;
    assign RSP_VALID = s_r.rsp;
    assign RSP_RDATA = s_r.rdata;
    assign MEM_ADDR = s_r.addr;
    assign MEM_SEL_N = s_r.sel_n;
    assign MEM_WSTROBE_N = s_r.we_n;
    assign MEM_OUTEN_N = s_r.oe_n;
    assign MEM_DQ_O = s_r.dq_o;
    assign MEM_DQ_OE = s_r.dq_oe;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_no_contention: assert property (!(MEM_DQ_OE && !MEM_OUTEN_N))
        else $error("host drives data while memory outputs enabled");
    a_write_addr_hold: assert property (!MEM_WSTROBE_N |=> $stable(MEM_ADDR))
        else $error("address moved during write pulse");
    a_write_width: assert property ($fell(MEM_WSTROBE_N) |-> !MEM_WSTROBE_N [*2])
        else $error("write pulse too short");
    a_write_sel: assert property (!MEM_WSTROBE_N |-> !MEM_SEL_N && MEM_DQ_OE)
        else $error("write strobe without select or data");
    a_read_period: assert property ($fell(MEM_OUTEN_N) |-> !MEM_OUTEN_N [*4])
        else $error("read released before access time");
    a_read_mode: assert property (!MEM_OUTEN_N |-> MEM_WSTROBE_N && !MEM_SEL_N)
        else $error("read without select or with strobe");
    a_rsp_after_read: assert property (RSP_VALID |-> !$past(MEM_OUTEN_N))
        else $error("response without read");
    a_ready_idle: assert property (REQ_READY |-> MEM_SEL_N)
        else $error("select held while idle");
    a_read_addr_hold: assert property (!MEM_OUTEN_N |=> $stable(MEM_ADDR))
        else $error("address moved during read access");
    a_write_data: assert property (!MEM_WSTROBE_N |=> $stable(MEM_DQ_O) && MEM_DQ_OE)
        else $error("write data moved during write pulse");
    a_strobe_ends: assert property ($rose(MEM_WSTROBE_N) |-> !MEM_SEL_N)
        else $error("select dropped before write strobe rose");
    a_float_first: assert property ($rose(MEM_DQ_OE) |-> $past(MEM_OUTEN_N))
        else $error("host drives data before memory outputs floated");

    c_read: cover property (RSP_VALID);
    c_write: cover property ($rose(MEM_WSTROBE_N));
    c_back: cover property (RSP_VALID ##[1:3] !MEM_WSTROBE_N);
    c_write_read: cover property ($rose(MEM_WSTROBE_N) ##[1:4] $fell(MEM_OUTEN_N));
endmodule : asm_host
`default_nettype wire

//--- asm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module asm_mem_model (
    input wire logic [18:0] addr,
    input wire logic sel_n,
    input wire logic wstrobe_n,
    input wire logic outen_n,
    input wire logic [7:0] host_dq,
    input wire logic host_oe,
    output logic [7:0] bus,
    output logic clash
);
    logic [7:0] mem [int];
    logic [7:0] last = 8'h00;
    realtime t_chg = 0;
    logic drv;
    always @(addr or sel_n or outen_n or wstrobe_n) t_chg = $realtime;
    assign drv = !sel_n && !outen_n && wstrobe_n;
    initial clash = 1'b0;
    // Released lines show the inverse of the last value, so a stale read is never lucky.
    always #1 begin
        if (host_oe && drv) clash = 1'b1;
        if (host_oe) last = host_dq;
        if (host_oe && !sel_n && !wstrobe_n) mem[addr] = host_dq;
        if (host_oe) bus = host_dq;
        else if (drv && $realtime - t_chg >= 20.0) begin
            last = mem.exists(addr) ? mem[addr] : 8'h00;
            bus = last;
        end else bus = ~last;
    end
endmodule : asm_mem_model
`default_nettype wire

//--- test_async_sram_512k_x8_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_async_sram_512k_x8_port;
    import asm_pkg::*;
    logic clk, rst, req_valid, req_write, req_ready, rsp_valid;
    logic sel_n, wstrobe_n, outen_n, dq_oe, clash;
    logic [ADDR_W-1:0] req_addr, mem_addr;
    logic [DATA_W-1:0] req_wdata, rsp_rdata, dq_o, bus;
    int fail_count, total_checks, cycles;
    logic [7:0] ref_mem [int];
    logic [18:0] a;
    asm_host i_dut (.CLK(clk), .RST(rst), .REQ_VALID(req_valid), .REQ_WRITE(req_write),
        .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .REQ_READY(req_ready),
        .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .MEM_ADDR(mem_addr),
        .MEM_SEL_N(sel_n), .MEM_WSTROBE_N(wstrobe_n), .MEM_OUTEN_N(outen_n),
        .MEM_DQ_I(bus), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe));
    asm_mem_model i_mem (.addr(mem_addr), .sel_n(sel_n), .wstrobe_n(wstrobe_n),
        .outen_n(outen_n), .host_dq(dq_o), .host_oe(dq_oe), .bus(bus), .clash(clash));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        if (fail_count == 0 && total_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    // A hung handshake must still reach the verdict.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test();
        end
    end
    task automatic do_req(input logic w, input logic [18:0] ad, input logic [7:0] d);
        int n;
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= ad;
        req_wdata <= d;
        @(negedge clk);
        while (req_ready !== 1'b1) @(negedge clk);
        @(posedge clk);
        req_valid <= 1'b0;
        n = 0;
        if (w) begin
            ref_mem[ad] = d;
            // Let an edge pass so the next request never re-raises valid in this step.
            @(posedge clk);
        end else begin
            @(negedge clk);
            while (rsp_valid !== 1'b1 && n < 20) begin
                @(posedge clk);
                n++;
                @(negedge clk);
            end
            check(n, 5);
            check(rsp_rdata, ref_mem.exists(ad) ? ref_mem[ad] : 8'h00);
            @(posedge clk);
        end
    endtask : do_req
    initial begin
        rst = 1'b1;
        req_valid = 1'b0;
        req_write = 1'b0;
        req_addr = '0;
        req_wdata = '0;
        void'($urandom(74));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        check({req_ready, sel_n, wstrobe_n, outen_n, dq_oe}, 5'b1_1110);
        @(posedge clk);
        do_req(1'b0, 19'h0_0001, 8'h00);
        for (int i = 0; i < 3; i++) begin
            a = (i == 0) ? 19'h0_0000 : (i == 1) ? 19'h7_FFFF : 19'h4_0000;
            do_req(1'b1, a, 8'($urandom));
            do_req(1'b0, a, 8'h00);
            do_req(1'b0, a, 8'h00);
        end
        for (int i = 0; i < 60; i++) begin
            a = 19'($urandom_range(0, 15)) | ($urandom_range(0, 1) ? 19'h7_FFF0 : 19'h0_0000);
            do_req(1'($urandom), a, 8'($urandom));
        end
        check(clash, 1'b0);
        end_of_test();
    end
endmodule : test_async_sram_512k_x8_port
`default_nettype wire
